// >>> verilog/lock_detect_pkg.sv
// Purpose: shared constants for the lock detect and pin qualify block
// Assumes: 32-bit AHB-Lite register bus, 16-bit registers in the low bits
// Notes:   byte address of a register is four times its index
`default_nettype none
package lock_detect_pkg;
    // ------------------------------------------------------------
    // register indexes and address width
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_ALIGN_CTRL   = 8'h00;
    localparam logic [7:0] IDX_LOCK_STATUS  = 8'h01;
    localparam logic [7:0] IDX_PIN_QUALIFY  = 8'h3a;
    localparam logic [7:0] IDX_LOCK_SOURCE  = 8'h3b;
    localparam logic [7:0] IDX_SETTLE_DELAY = 8'h3c;
    localparam int         ADDR_W           = 10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          PIN_IGNORE_BIT     = 15;
    localparam int          LOCK_SOURCE_BIT    = 0;
    localparam int          ALIGN_ENABLE_BIT   = 0;
    localparam logic [15:0] PIN_QUALIFY_RESET  = 16'h8001;
    localparam logic [15:0] LOCK_SOURCE_RESET  = 16'h0001;
    localparam logic [15:0] SETTLE_DELAY_RESET = 16'h03e8;
    localparam logic [15:0] ALIGN_CTRL_RESET   = 16'h0000;

    // ------------------------------------------------------------
    // timing: the delay counts quarter cycles of the clock
    // ------------------------------------------------------------
    localparam int QUARTERS_PER_CLK = 4;

    typedef enum logic [2:0]
    {
        ST_CALIBRATING = 3'b001,
        ST_SETTLING    = 3'b010,
        ST_LOCKED      = 3'b100
    } lock_state_t;
endpackage
`default_nettype wire

// >>> verilog/lock_detect_and_pin_qualify.sv
// Purpose: pin qualification and lock indicator with an AHB-Lite register slave
// Assumes: clk is the phase detector clock; pins and calibration flags synchronous
// Notes:   zero wait state slave; response always OKAY
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - with alignment off and pin_ignore set, sync and request pins are ignored
// - pin qualify register resets to 0x8001, pin_ignore bit 15 set
// - lock source bit 0: 0 calibration only, 1 adds tuning voltage; resets 1
// - calibration-only lock rises after calibration done and settle count expired
// - combined mode also needs tuning voltage inside its window
// - 16-bit settle count sets post-calibration wait in quarter clock cycles
// - settle delay register resets to 0x3e8
module lock_detect_and_pin_qualify #(
    parameter int DELAY_W = 16
) (
    input  wire logic                                clk,
    input  wire logic                                reset,
    input  wire logic                                hsel,
    input  wire logic [lock_detect_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output var  logic                                hreadyout,
    output var  logic                                hresp,
    output var  logic [31:0]                         hrdata,
    input  wire logic                                syncPin,
    input  wire logic                                refRequestPin,
    input  wire logic                                calStart,
    input  wire logic                                calDone,
    input  wire logic                                tuneInRange,
    output var  logic                                syncQualified,
    output var  logic                                refRequestQualified,
    output var  logic                                lockIndicator
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [15:0]  pinQualify;
    logic [15:0]  lockSource;
    logic [15:0]  settleDelay;
    logic [15:0]  alignCtrl;
    logic         wrPending;
    logic [7:0]   wrIndex;
    logic [15:0]  next_pinQualify;
    logic [15:0]  next_lockSource;
    logic [15:0]  next_settleDelay;
    logic [15:0]  next_alignCtrl;
    logic         next_wrPending;
    logic [7:0]   next_wrIndex;
    logic [31:0]  next_hrdata;
    logic         addrPhase;
    logic [7:0]   addrIndex;
    lock_detect_pkg::lock_state_t state;
    lock_detect_pkg::lock_state_t next_state;
    logic [DELAY_W-1:0] settleCount;
    logic [DELAY_W-1:0] next_settleCount;
    logic         next_lockIndicator;
    logic         pinsIgnored;

    assign addrPhase = hsel && htrans[1] && hready;
    assign addrIndex = haddr[9:2];

    always_comb
    begin
        next_pinQualify  = pinQualify;
        next_lockSource  = lockSource;
        next_settleDelay = settleDelay;
        next_alignCtrl   = alignCtrl;
        if (wrPending)
        begin
            unique case (wrIndex)
                lock_detect_pkg::IDX_PIN_QUALIFY:  next_pinQualify  = hwdata[15:0];
                lock_detect_pkg::IDX_LOCK_SOURCE:  next_lockSource  = hwdata[15:0];
                lock_detect_pkg::IDX_SETTLE_DELAY: next_settleDelay = hwdata[15:0];
                lock_detect_pkg::IDX_ALIGN_CTRL:   next_alignCtrl   = hwdata[15:0];
                default:                           next_alignCtrl   = alignCtrl;
            endcase
        end
        next_wrPending = addrPhase && hwrite;
        next_wrIndex   = addrIndex;
        // read forwards a write finishing this cycle, so back to back is safe
        next_hrdata = hrdata;
        if (addrPhase && !hwrite)
        begin
            unique case (addrIndex)
                lock_detect_pkg::IDX_PIN_QUALIFY:  next_hrdata = {16'h0000, next_pinQualify};
                lock_detect_pkg::IDX_LOCK_SOURCE:  next_hrdata = {16'h0000, next_lockSource};
                lock_detect_pkg::IDX_SETTLE_DELAY: next_hrdata = {16'h0000, next_settleDelay};
                lock_detect_pkg::IDX_ALIGN_CTRL:   next_hrdata = {16'h0000, next_alignCtrl};
                lock_detect_pkg::IDX_LOCK_STATUS:
                    next_hrdata = {28'h0000000, lockIndicator, state};
                default:                           next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pinQualify  <= lock_detect_pkg::PIN_QUALIFY_RESET;
            lockSource  <= lock_detect_pkg::LOCK_SOURCE_RESET;
            settleDelay <= lock_detect_pkg::SETTLE_DELAY_RESET;
            alignCtrl   <= lock_detect_pkg::ALIGN_CTRL_RESET;
            wrPending   <= 1'b0;
            wrIndex     <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
        else
        begin
            pinQualify  <= next_pinQualify;
            lockSource  <= next_lockSource;
            settleDelay <= next_settleDelay;
            alignCtrl   <= next_alignCtrl;
            wrPending   <= next_wrPending;
            wrIndex     <= next_wrIndex;
            hrdata      <= next_hrdata;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin qualification
    // ------------------------------------------------------------
    assign pinsIgnored = pinQualify[lock_detect_pkg::PIN_IGNORE_BIT]
                         && !alignCtrl[lock_detect_pkg::ALIGN_ENABLE_BIT];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            syncQualified       <= 1'b0;
            refRequestQualified <= 1'b0;
        end
        else
        begin
            syncQualified       <= syncPin && !pinsIgnored;
            refRequestQualified <= refRequestPin && !pinsIgnored;
        end
    end

    // ------------------------------------------------------------
    // lock detect
    // ------------------------------------------------------------
    always_comb
    begin
        next_state       = state;
        next_settleCount = settleCount;
        if (calStart)
        begin
            next_state = lock_detect_pkg::ST_CALIBRATING;
        end
        else
        begin
            unique case (state)
                lock_detect_pkg::ST_CALIBRATING:
                    if (calDone)
                    begin
                        // quarter cycles rounded up to whole clocks
                        next_state       = lock_detect_pkg::ST_SETTLING;
                        next_settleCount = DELAY_W'((32'(settleDelay)
                                           + 32'(lock_detect_pkg::QUARTERS_PER_CLK - 1))
                                           / 32'(lock_detect_pkg::QUARTERS_PER_CLK));
                    end
                lock_detect_pkg::ST_SETTLING:
                    if (settleCount <= DELAY_W'(1))
                    begin
                        next_state = lock_detect_pkg::ST_LOCKED;
                    end
                    else
                    begin
                        next_settleCount = settleCount - DELAY_W'(1);
                    end
                lock_detect_pkg::ST_LOCKED:
                    next_state = lock_detect_pkg::ST_LOCKED;
                default:
                    next_state = lock_detect_pkg::ST_CALIBRATING;
            endcase
        end
        next_lockIndicator = (next_state == lock_detect_pkg::ST_LOCKED)
                             && (!lockSource[lock_detect_pkg::LOCK_SOURCE_BIT]
                                 || tuneInRange);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state         <= lock_detect_pkg::ST_CALIBRATING;
            settleCount   <= '0;
            lockIndicator <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            settleCount   <= next_settleCount;
            lockIndicator <= next_lockIndicator;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_pins_ignored;
        (pinQualify[15] && !alignCtrl[0]) |=> !syncQualified && !refRequestQualified;
    endproperty
    a_pins_ignored: assert property (p_pins_ignored) else $error("pin passed while ignored");

    property p_pins_pass;
        (!pinQualify[15] || alignCtrl[0]) |=> syncQualified == $past(syncPin)
            && refRequestQualified == $past(refRequestPin);
    endproperty
    a_pins_pass: assert property (p_pins_pass) else $error("qualified pin lost");

    property p_qualify_reset;
        disable iff (1'b0) reset |=> pinQualify == 16'h8001;
    endproperty
    a_qualify_reset: assert property (p_qualify_reset) else $error("bad qualify reset");

    property p_source_reset;
        disable iff (1'b0) reset |=> lockSource == 16'h0001;
    endproperty
    a_source_reset: assert property (p_source_reset) else $error("bad source reset");

    property p_delay_reset;
        disable iff (1'b0) reset |=> settleDelay == 16'h03e8;
    endproperty
    a_delay_reset: assert property (p_delay_reset) else $error("bad delay reset");

    property p_lock_needs_settle;
        $rose(lockIndicator) |-> $past(state) != lock_detect_pkg::ST_CALIBRATING;
    endproperty
    a_lock_needs_settle: assert property (p_lock_needs_settle) else $error("lock before settle");

    property p_tune_gate;
        (lockSource[0] && !tuneInRange) |=> !lockIndicator;
    endproperty
    a_tune_gate: assert property (p_tune_gate) else $error("lock outside tune window");

    // delays of 0 to 4 quarter cycles all settle in one whole clock
    sequence s_short_settle;
        state == lock_detect_pkg::ST_CALIBRATING && calDone && !calStart
            && settleDelay <= 16'h0004 && !lockSource[0] ##1 !calStart;
    endsequence
    property p_short_settle;
        s_short_settle |=> lockIndicator;
    endproperty
    a_short_settle: assert property (p_short_settle) else $error("settle timing off");

    property p_counting_unlocked;
        (state == lock_detect_pkg::ST_SETTLING && settleCount > DELAY_W'(1) && !calStart)
            |=> !lockIndicator && state == lock_detect_pkg::ST_SETTLING;
    endproperty
    a_counting_unlocked: assert property (p_counting_unlocked) else $error("early lock");

    property p_cal_restart;
        calStart |=> !lockIndicator && state == lock_detect_pkg::ST_CALIBRATING;
    endproperty
    a_cal_restart: assert property (p_cal_restart) else $error("lock kept over calibration");
endmodule
`default_nettype wire

// >>> tb/ahb_host_model.sv
// Purpose: AHB-Lite master standing in for the host controller
// Assumes: single aligned word transfers, slave may insert wait states
// Notes:   signals change by NBA right after a rising edge only
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [9:0]  haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 10'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    // one single transfer; waits on hready, no fixed latency assumed
    task automatic xfer(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge clk); while (hready !== 1'b1);
        rdata = hrdata;
        // released data must not keep showing the last word
        hwdata <= ~wdata;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_lock_detect_and_pin_qualify.sv
// Purpose: self-checking bench for the lock detect and pin qualify block
// Assumes: zero or more wait states on the register bus
// Notes:   settle wait is ceil(delay/4) clocks, zero treated as one
`timescale 1ns/1ps
`default_nettype none
module test_lock_detect_and_pin_qualify;
    localparam logic [9:0] A_ALIGN = {lock_detect_pkg::IDX_ALIGN_CTRL, 2'b00};
    localparam logic [9:0] A_PINQ  = {lock_detect_pkg::IDX_PIN_QUALIFY, 2'b00};
    localparam logic [9:0] A_SRC   = {lock_detect_pkg::IDX_LOCK_SOURCE, 2'b00};
    localparam logic [9:0] A_DLY   = {lock_detect_pkg::IDX_SETTLE_DELAY, 2'b00};
    localparam logic [9:0] A_STAT  = {lock_detect_pkg::IDX_LOCK_STATUS, 2'b00};
    logic        clk, reset, hsel, hwrite, hreadyout, hresp;
    logic [9:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        syncPin, refRequestPin, calStart, calDone, tuneInRange;
    logic        syncQualified, refRequestQualified, lockIndicator;
    int          fail_count = 0;
    int          checks_done = 0;

    lock_detect_and_pin_qualify dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .syncPin(syncPin),
        .refRequestPin(refRequestPin), .calStart(calStart), .calDone(calDone),
        .tuneInRange(tuneInRange), .syncQualified(syncQualified),
        .refRequestQualified(refRequestQualified), .lockIndicator(lockIndicator));
    ahb_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, {16'h0000, d}, r);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] r);
        host.xfer(1'b0, a, 32'h00000000, r);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic done);
        @(posedge clk);
        if (done) calDone <= 1'b1;
        else calStart <= 1'b1;
        @(posedge clk);
        calDone <= 1'b0;
        calStart <= 1'b0;
    endtask
    // calibration, then lock must rise exactly ceil(dly/4) edges after done, one edge for zero
    task automatic settle(input int dly);
        int n;
        n = (dly == 0) ? 1 : (dly + 3) / 4;
        pulse(1'b0);
        wt(1);
        chk(32'(lockIndicator), 32'h0);
        pulse(1'b1);
        for (int i = 1; i <= n; i++)
        begin
            wt(1);
            chk(32'(lockIndicator), 32'(i >= n));
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        rd(A_PINQ, r);
        chk(r, 32'h8001);
        rd(A_SRC, r);
        chk(r, 32'h0001);
        rd(A_DLY, r);
        chk(r, 32'h03e8);
        rd(10'h3fc, r);
        chk({r[31:1], hresp}, 32'h0);
        chk(32'(hreadyout), 32'h1);
    endtask
    task automatic t_pins();
        syncPin <= 1'b1;
        refRequestPin <= 1'b1;
        wt(3);
        chk(32'({syncQualified, refRequestQualified}), 32'h0);
        wr(A_ALIGN, 16'h0001);
        wt(3);
        chk(32'({syncQualified, refRequestQualified}), 32'h3);
        wr(A_ALIGN, 16'h0000);
        wr(A_PINQ, 16'h0001);
        // pins differ so a swapped path shows up
        refRequestPin <= 1'b0;
        wt(3);
        chk(32'({syncQualified, refRequestQualified}), 32'h2);
        wr(A_PINQ, 16'h8001);
        wt(3);
        chk(32'({syncQualified, refRequestQualified}), 32'h0);
    endtask
    task automatic t_lock();
        logic [31:0] r;
        // tuning voltage out of window must not matter in calibration-only mode
        wr(A_SRC, 16'h0000);
        wr(A_DLY, 16'h0005);
        settle(5);
        rd(A_STAT, r);
        chk(r, 32'h0000000c);
        wr(A_DLY, 16'h0000);
        settle(0);
        wr(A_SRC, 16'h0001);
        wr(A_DLY, 16'h0008);
        pulse(1'b0);
        pulse(1'b1);
        wt(5);
        chk(32'(lockIndicator), 32'h0);
        @(posedge clk);
        tuneInRange <= 1'b1;
        wt(2);
        chk(32'(lockIndicator), 32'h1);
        @(posedge clk);
        tuneInRange <= 1'b0;
        wt(2);
        chk(32'(lockIndicator), 32'h0);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial
    begin
        reset = 1'b1;
        {syncPin, refRequestPin, calStart, calDone, tuneInRange} = 5'b00000;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_pins();
        t_lock();
        end_sim();
    end
endmodule
`default_nettype wire
